// *** hw/sad_params.svh ***
// Purpose: Offsets, field positions, reset values of the attribution block
// Assumes: Byte addresses on an 8-bit register port, 32-bit data
// Notes:   Definitions only
`ifndef SAD_PARAMS_SVH
`define SAD_PARAMS_SVH
`define SAD_OFF_CTRL      8'h00
`define SAD_OFF_STAT      8'h04
`define SAD_OFF_COL_EN    8'h08
`define SAD_OFF_COL_FLAG  8'h0C
`define SAD_OFF_PERI_SEC  8'h10
`define SAD_OFF_GPIO_SEC  8'h14
`define SAD_OFF_IRQ_SEC   8'h18
`define SAD_OFF_GUARD_SEC 8'h1C
`define SAD_OFF_RGN_BASE  8'h40
`define SAD_RGN_STRIDE    8'h08
`define SAD_RGN_LIM_OFS   8'h04
`define SAD_RGN_EN_BIT    0
`define SAD_RGN_NSC_BIT   1
`define SAD_RGN_LSB       5
`define SAD_CTRL_EN_BIT   0
`define SAD_NSC_FLASH_LO  32'h0C00_0000
`define SAD_NSC_FLASH_HI  32'h0FFF_FFFF
`define SAD_NSC_SRAM_LO   32'h3000_0000
`define SAD_NSC_SRAM_HI   32'h3FFF_FFFF
`define SAD_NSC_PERI_LO   32'h5000_0000
`define SAD_NSC_PERI_HI   32'h5FFF_FFFF
`define SAD_FLASH_NS_LO   32'h0800_0000
`define SAD_FLASH_MASK    32'h03FF_FFFF
`define SAD_FLASH_PG_LSB  13
`define SAD_GUARD_NS_BASE 32'h2000_0000
`define SAD_GUARD_S_BASE  32'h3000_0000
`define SAD_GUARD_PG_LSB  9
`define SAD_BOOT_DEFAULT  32'h0C00_0000
`define SAD_SRC_ATTR      0
`define SAD_SRC_GUARD     1
`define SAD_SRC_GATE      2
`endif

// *** hw/sad_pkg.sv ***
// Purpose: Types shared by the attribution block
// Assumes: Ordering of codes is the order of security
// Notes:   Larger code is more secure, so a max picks the final value
package sad_pkg;
  typedef enum logic [1:0] {
    SAD_NONSEC = 2'b00,
    SAD_NSC    = 2'b01,
    SAD_SECURE = 2'b10
  } sad_attr_e;
endpackage : sad_pkg

// *** hw/sad_region.sv ***
// Purpose: One programmable attribution region compare
// Assumes: Base and limit on 32-byte granules, limit inclusive
// Notes:   Purely combinational, no added wait state
`timescale 1ns/1ps
module sad_region #(
  parameter int LSB = 5
) (
  // Access address
  input  wire logic [31:0] addr,
  // Region settings
  input  wire logic [31:0] base,
  input  wire logic [31:0] limit,
  input  wire logic        en,
  // Result
  output logic             hit
);
  // Granule compare against the inclusive window
  assign hit = en && (addr[31:LSB] >= base[31:LSB]) && (addr[31:LSB] <= limit[31:LSB]);
endmodule : sad_region

// *** hw/sad_top.sv ***
// Purpose: Security attribution and reset-time security defaults
// Assumes: One clock, register port with read data one cycle after strobe
// Notes:   Access check is combinational within the access cycle
// Notes on behaviour
// - Security checks apply only while the security enable option is set.
// - Grant or deny each access from both attribution results and requester state.
// - Up to eight programmable regions each assign an attribute to a range.
// - Fixed map gives non-secure or callable; more secure of both results wins.
// - Flash, SRAM and peripherals appear at a secure and a non-secure alias.
// - Range 0x0C000000 to 0x0FFFFFFF is tagged callable by the fixed map.
// - Each securable peripheral has a gate whose security is set by configuration.
// - Security-aware peripherals bypass the gate and apply their own behaviour.
// - Processor starts secure after reset; boot address must be secure.
// - Programmable unit makes every address secure at reset.
// - Flash secure area set by watermark options; block-based flash non-secure.
// - All SRAM pages secure at reset; guard configuration itself secure.
// - Securable and security-aware peripherals are non-secure at reset.
// - Every general-purpose I/O resets to secure.
// - Every interrupt secure at reset; interrupt state banked per world.
// - All illegal-access sources disabled in the collector at reset.
// - Collector gathers illegal-access events into one secure interrupt.
// - Block guard holds one secure bit per 512-byte SRAM page.
`timescale 1ns/1ps
`include "sad_params.svh"
module sad_top #(
  parameter int NRGN   = 8,
  parameter int NPERI  = 32,
  parameter int NGPIO  = 32,
  parameter int NIRQ   = 32,
  parameter int NPAGE  = 32,
  parameter int FPAGEW = 7
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  // Option pins from the flash option word
  input  wire logic                opt_sec_enable,
  input  wire logic [FPAGEW-1:0]   opt_wm_start,
  input  wire logic [FPAGEW-1:0]   opt_wm_end,
  input  wire logic [31:0]         opt_boot_addr,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic                reg_nonsec,
  output logic      [31:0]         reg_rdata,
  // Bus access under check
  input  wire logic                acc_valid,
  input  wire logic [31:0]         acc_addr,
  input  wire logic                acc_nonsec,
  input  wire logic                acc_fetch,
  input  wire logic                acc_peri,
  input  wire logic                acc_peri_aware,
  input  wire logic [4:0]          acc_peri_idx,
  output logic                     acc_grant,
  output logic                     acc_block,
  output sad_pkg::sad_attr_e       acc_attr,
  // Security state toward the system
  output logic                     sec_enabled,
  output logic                     cpu_secure,
  output logic [31:0]              boot_addr,
  output logic [NGPIO-1:0]         gpio_secure,
  output logic [NIRQ-1:0]          irq_line_secure,
  output logic [NPERI-1:0]         peri_secure,
  // Collector interrupt toward the interrupt controller
  output logic                     col_irq
);
  // Option pins come from outside the clock domain
  logic              opt_s1_q, opt_s2_q;
  logic              strap_done_q;
  logic              sec_en_q;
  logic [31:0]       boot_q;
  logic [FPAGEW-1:0] wm_lo_q, wm_hi_q;
  logic [2*FPAGEW+31:0] optw_s1_q, optw_s2_q;
  logic [31:0]       boot_sync;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      opt_s1_q <= 1'b0;
      opt_s2_q <= 1'b0;
    end else begin
      opt_s1_q <= opt_sec_enable;
      opt_s2_q <= opt_s1_q;
    end
  end

  // Options caught once the synced enable reads set; while it reads clear they are resampled every cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strap_done_q <= 1'b0;
      sec_en_q     <= 1'b0;
      boot_q       <= `SAD_BOOT_DEFAULT;
      wm_lo_q      <= '0;
      wm_hi_q      <= '0;
    end else if (!strap_done_q) begin
      strap_done_q <= opt_s2_q;
      sec_en_q     <= opt_s2_q;
      wm_lo_q      <= optw_s2_q[FPAGEW-1:0];
      wm_hi_q      <= optw_s2_q[2*FPAGEW-1:FPAGEW];
      // With security enabled, a boot address outside the secure flash alias is forced back
      if (opt_s2_q && (boot_sync < `SAD_NSC_FLASH_LO || boot_sync > `SAD_NSC_FLASH_HI))
        boot_q <= `SAD_BOOT_DEFAULT;
      else
        boot_q <= boot_sync;
    end
  end
  // Static option words pass the same two stages as the enable
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      optw_s1_q <= '0;
      optw_s2_q <= '0;
    end else begin
      optw_s1_q <= {opt_boot_addr, opt_wm_end, opt_wm_start};
      optw_s2_q <= optw_s1_q;
    end
  end
  assign boot_sync = optw_s2_q[2*FPAGEW +: 32];

  // Register storage
  logic             sau_en_q;
  logic [31:0]      rgn_base_q [NRGN];
  logic [31:0]      rgn_lim_q  [NRGN];
  logic [2:0]       col_en_q, col_flag_q;
  logic [NPERI-1:0] peri_q;
  logic [NGPIO-1:0] gpio_q;
  logic [NIRQ-1:0]  irq_q;
  logic [NPAGE-1:0] guard_q;
  logic             cpu_sec_q;

  // Non-secure writes never touch secure configuration while security is enabled
  logic wr_ok;
  assign wr_ok = reg_wr && !(reg_nonsec && sec_en_q);

  // Programmable unit enable; off means every address secure
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      sau_en_q <= 1'b0;
    else if (wr_ok && reg_addr == `SAD_OFF_CTRL)
      sau_en_q <= reg_wdata[`SAD_CTRL_EN_BIT];
  end

  // Region base and limit words, regions disabled at reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NRGN; i++) begin
        rgn_base_q[i] <= 32'h0000_0000;
        rgn_lim_q[i]  <= 32'h0000_0000;
      end
    end else if (wr_ok) begin
      for (int i = 0; i < NRGN; i++) begin
        if (reg_addr == 8'(`SAD_OFF_RGN_BASE + i * `SAD_RGN_STRIDE))
          rgn_base_q[i] <= reg_wdata;
        if (reg_addr == 8'(`SAD_OFF_RGN_BASE + i * `SAD_RGN_STRIDE + `SAD_RGN_LIM_OFS))
          rgn_lim_q[i] <= reg_wdata;
      end
    end
  end

  // Gate, I/O, interrupt and page security words
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      peri_q  <= '0;
      gpio_q  <= '1;
      irq_q   <= '1;
      guard_q <= '1;
    end else if (wr_ok) begin
      if (reg_addr == `SAD_OFF_PERI_SEC)  peri_q  <= reg_wdata[NPERI-1:0];
      if (reg_addr == `SAD_OFF_GPIO_SEC)  gpio_q  <= reg_wdata[NGPIO-1:0];
      if (reg_addr == `SAD_OFF_IRQ_SEC)   irq_q   <= reg_wdata[NIRQ-1:0];
      if (reg_addr == `SAD_OFF_GUARD_SEC) guard_q <= reg_wdata[NPAGE-1:0];
    end
  end

  // Processor state after reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      cpu_sec_q <= 1'b1;
    else
      cpu_sec_q <= cpu_sec_q;
  end

  // Programmable regions, one compare each
  logic [NRGN-1:0] rgn_hit;
  logic [NRGN-1:0] rgn_nsc;
  genvar g;
  generate
    for (g = 0; g < NRGN; g++) begin : g_rgn
      sad_region #(.LSB(`SAD_RGN_LSB)) u_rgn (
        .addr  (acc_addr),
        .base  (rgn_base_q[g]),
        .limit (rgn_lim_q[g]),
        .en    (rgn_lim_q[g][`SAD_RGN_EN_BIT]),
        .hit   (rgn_hit[g])
      );
      assign rgn_nsc[g] = rgn_lim_q[g][`SAD_RGN_NSC_BIT];
    end
  endgenerate

  // Programmable result: lowest hitting region wins, default secure
  sad_pkg::sad_attr_e sau_attr;
  always_comb begin
    sau_attr = sad_pkg::SAD_SECURE;
    if (sau_en_q) begin
      for (int i = NRGN - 1; i >= 0; i--) begin
        if (rgn_hit[i])
          sau_attr = rgn_nsc[i] ? sad_pkg::SAD_NSC : sad_pkg::SAD_NONSEC;
      end
    end
  end

  // Fixed map: secure aliases are callable, everything else non-secure
  sad_pkg::sad_attr_e fixed_attribution_map_attr;
  always_comb begin
    fixed_attribution_map_attr = sad_pkg::SAD_NONSEC;
    if ((acc_addr >= `SAD_NSC_FLASH_LO && acc_addr <= `SAD_NSC_FLASH_HI) ||
        (acc_addr >= `SAD_NSC_SRAM_LO  && acc_addr <= `SAD_NSC_SRAM_HI)  ||
        (acc_addr >= `SAD_NSC_PERI_LO  && acc_addr <= `SAD_NSC_PERI_HI))
      fixed_attribution_map_attr = sad_pkg::SAD_NSC;
  end

  // More secure result wins, no register in the path
  sad_pkg::sad_attr_e fin_attr;
  always_comb begin
    fin_attr = (fixed_attribution_map_attr > sau_attr) ? fixed_attribution_map_attr : sau_attr;
  end

  // Flash watermark area is secure; outside it the attribution result alone decides
  logic [31:0]       flash_ofs;
  logic [FPAGEW-1:0] flash_pg;
  logic              in_flash, flash_sec;
  assign in_flash  = (acc_addr >= `SAD_FLASH_NS_LO) && (acc_addr <= `SAD_NSC_FLASH_HI);
  assign flash_ofs = acc_addr & `SAD_FLASH_MASK;
  assign flash_pg  = flash_ofs[`SAD_FLASH_PG_LSB +: FPAGEW];
  assign flash_sec = (flash_pg >= wm_lo_q) && (flash_pg <= wm_hi_q);

  // Guarded SRAM page lookup, same pages seen through both aliases
  localparam int PGW = $clog2(NPAGE);
  logic           in_guard;
  logic [PGW-1:0] pg_idx;
  logic [31:0]    guard_ofs;
  always_comb begin
    in_guard  = 1'b0;
    guard_ofs = 32'h0000_0000;
    if (acc_addr >= `SAD_GUARD_NS_BASE && acc_addr < `SAD_GUARD_NS_BASE + (NPAGE << `SAD_GUARD_PG_LSB)) begin
      in_guard  = 1'b1;
      guard_ofs = acc_addr - `SAD_GUARD_NS_BASE;
    end else if (acc_addr >= `SAD_GUARD_S_BASE && acc_addr < `SAD_GUARD_S_BASE + (NPAGE << `SAD_GUARD_PG_LSB)) begin
      in_guard  = 1'b1;
      guard_ofs = acc_addr - `SAD_GUARD_S_BASE;
    end
  end
  assign pg_idx = guard_ofs[`SAD_GUARD_PG_LSB +: PGW];

  // Access decision; checks bypassed while security is off
  logic attr_bad, guard_bad, gate_bad, req_sec;
  always_comb begin
    req_sec  = !acc_nonsec;
    attr_bad = 1'b0;
    if (acc_nonsec)
      attr_bad = (fin_attr == sad_pkg::SAD_SECURE) ||
                 (fin_attr == sad_pkg::SAD_NSC && !acc_fetch);
    else
      attr_bad = (fin_attr == sad_pkg::SAD_NONSEC);
    guard_bad = in_guard && (guard_q[pg_idx] != req_sec);
    if (in_flash && flash_sec && acc_nonsec)
      attr_bad = 1'b1;
    // Aware peripherals do their own checking behind the bus
    gate_bad = acc_peri && !acc_peri_aware && (peri_q[acc_peri_idx] != req_sec);
  end

  logic any_bad;
  assign any_bad   = sec_en_q && (attr_bad || guard_bad || gate_bad);
  assign acc_block = acc_valid && any_bad;
  assign acc_grant = acc_valid && !any_bad;
  assign acc_attr  = sec_en_q ? fin_attr : sad_pkg::SAD_NONSEC;

  // Collector flags: set wins over a write-one clear in the same cycle
  logic [2:0] evt;
  assign evt[`SAD_SRC_ATTR]  = acc_valid && sec_en_q && attr_bad;
  assign evt[`SAD_SRC_GUARD] = acc_valid && sec_en_q && guard_bad;
  assign evt[`SAD_SRC_GATE]  = acc_valid && sec_en_q && gate_bad;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      col_en_q <= 3'h0;
    else if (wr_ok && reg_addr == `SAD_OFF_COL_EN)
      col_en_q <= reg_wdata[2:0];
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      col_flag_q <= 3'h0;
    else if (wr_ok && reg_addr == `SAD_OFF_COL_FLAG)
      col_flag_q <= (col_flag_q & ~reg_wdata[2:0]) | evt;
    else
      col_flag_q <= col_flag_q | evt;
  end

  // One secure interrupt from all enabled sources
  logic col_irq_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      col_irq_q <= 1'b0;
    else
      col_irq_q <= |(col_flag_q & col_en_q);
  end
  assign col_irq = col_irq_q;

  // Read data one cycle after the strobe, unmapped reads zero
  logic [31:0] rd_d, rd_q;
  always_comb begin
    rd_d = 32'h0000_0000;
    case (reg_addr)
      `SAD_OFF_CTRL:      rd_d = {31'h0, sau_en_q};
      `SAD_OFF_STAT:      rd_d = {29'h0, strap_done_q, cpu_sec_q, sec_en_q};
      `SAD_OFF_COL_EN:    rd_d = {29'h0, col_en_q};
      `SAD_OFF_COL_FLAG:  rd_d = {29'h0, col_flag_q};
      `SAD_OFF_PERI_SEC:  rd_d = 32'(peri_q);
      `SAD_OFF_GPIO_SEC:  rd_d = 32'(gpio_q);
      `SAD_OFF_IRQ_SEC:   rd_d = 32'(irq_q);
      `SAD_OFF_GUARD_SEC: rd_d = 32'(guard_q);
      default: begin
        for (int i = 0; i < NRGN; i++) begin
          if (reg_addr == 8'(`SAD_OFF_RGN_BASE + i * `SAD_RGN_STRIDE))
            rd_d = rgn_base_q[i];
          if (reg_addr == 8'(`SAD_OFF_RGN_BASE + i * `SAD_RGN_STRIDE + `SAD_RGN_LIM_OFS))
            rd_d = rgn_lim_q[i];
        end
      end
    endcase
    // Secure configuration hidden from non-secure readers
    if (reg_nonsec && sec_en_q && reg_addr != `SAD_OFF_STAT)
      rd_d = 32'h0000_0000;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      rd_q <= 32'h0000_0000;
    else if (reg_rd)
      rd_q <= rd_d;
    else
      rd_q <= 32'h0000_0000;
  end
  assign reg_rdata = rd_q;

  // Security state toward the system
  assign sec_enabled     = sec_en_q;
  assign cpu_secure      = cpu_sec_q;
  assign boot_addr       = boot_q;
  assign gpio_secure     = gpio_q;
  assign irq_line_secure = irq_q;
  assign peri_secure     = peri_q;
endmodule : sad_top

// *** bench/sad_top_sva.sv ***
// Purpose: Port-level checks of the attribution block
// Assumes: One clock, active-low asynchronous reset
// Notes:   Bound to the top module from the testbench file
`timescale 1ns/1ps
module sad_top_sva #(
  parameter int NPERI = 32,
  parameter int NGPIO = 32,
  parameter int NIRQ  = 32
) (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               resetn,
  // Access under check
  input wire logic               acc_valid,
  input wire logic [31:0]        acc_addr,
  input wire logic               acc_nonsec,
  input wire logic               acc_fetch,
  input wire logic               acc_grant,
  input wire logic               acc_block,
  input wire sad_pkg::sad_attr_e acc_attr,
  // Security state
  input wire logic               sec_enabled,
  input wire logic               cpu_secure,
  input wire logic [31:0]        boot_addr,
  input wire logic [NGPIO-1:0]   gpio_secure,
  input wire logic [NIRQ-1:0]    irq_line_secure,
  input wire logic [NPERI-1:0]   peri_secure,
  input wire logic               col_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Fixed callable alias span, 0x0C000000 to 0x0FFFFFFF
  logic in_alias;
  assign in_alias = (acc_addr[31:26] == 6'h03);

  off_grant_a: assert property (acc_valid && !sec_enabled |->
    acc_grant && !acc_block && acc_attr == sad_pkg::SAD_NONSEC) else $error("access checked while security off");
  one_answer_a: assert property (acc_valid |-> acc_grant ^ acc_block)
    else $error("grant and block disagree");
  alias_nsc_a: assert property (acc_valid && sec_enabled && in_alias |->
    acc_attr != sad_pkg::SAD_NONSEC) else $error("callable alias lost to non-secure");
  ns_to_s_a: assert property (acc_valid && sec_enabled && acc_nonsec &&
    acc_attr == sad_pkg::SAD_SECURE |-> acc_block) else $error("non-secure reached secure target");
  s_to_ns_a: assert property (acc_valid && sec_enabled && !acc_nonsec &&
    acc_attr == sad_pkg::SAD_NONSEC |-> acc_block) else $error("secure reached non-secure target");
  nsc_data_a: assert property (acc_valid && sec_enabled && acc_nonsec && !acc_fetch &&
    acc_attr == sad_pkg::SAD_NSC |-> acc_block) else $error("data access through callable area");
  boot_sec_a: assert property (sec_enabled |-> boot_addr[31:26] == 6'h03 && cpu_secure)
    else $error("boot outside secure area");
  gpio_rst_a: assert property ($rose(resetn) |-> gpio_secure == '1)
    else $error("pins not secure at reset");
  irq_rst_a: assert property ($rose(resetn) |-> irq_line_secure == '1)
    else $error("interrupts not secure at reset");
  peri_rst_a: assert property ($rose(resetn) |-> peri_secure == '0)
    else $error("peripheral gates secure at reset");
  col_rst_a: assert property ($rose(resetn) |-> !col_irq)
    else $error("collector interrupt at reset");

  // Main scenarios reached
  cover property (acc_valid && sec_enabled && acc_block);
  cover property (acc_valid && acc_attr == sad_pkg::SAD_NSC && acc_grant);
  cover property ($rose(col_irq));
endmodule : sad_top_sva

// *** bench/sad_core_model.sv ***
// Purpose: Bus master issuing accesses to the attribution check
// Assumes: Signals change only just after a rising edge
// Notes:   Access stays up until the next issue or stop
`timescale 1ns/1ps
module sad_core_model (
  // Clock
  input wire logic  clk_sys,
  // Access toward the check
  output logic        acc_valid,
  output logic [31:0] acc_addr,
  output logic        acc_nonsec,
  output logic        acc_fetch,
  output logic        acc_peri,
  output logic        acc_peri_aware,
  output logic [4:0]  acc_peri_idx
);
  // Idle at time zero
  initial begin
    acc_valid = 1'b0;
    {acc_addr, acc_nonsec, acc_fetch, acc_peri, acc_peri_aware, acc_peri_idx} = '0;
  end

  // One access, answered in its own cycle, so return at mid-cycle
  task automatic issue(logic [31:0] a, logic ns, logic f, logic p, logic aw);
    @(posedge clk_sys);
    acc_valid      <= 1'b1;
    acc_addr       <= a;
    acc_nonsec     <= ns;
    acc_fetch      <= f;
    acc_peri       <= p;
    acc_peri_aware <= aw;
    acc_peri_idx   <= 5'h03;
    @(negedge clk_sys);
  endtask : issue

  // Released bus shows the inverse, never a stale address
  task automatic stop();
    @(posedge clk_sys);
    acc_valid  <= 1'b0;
    acc_addr   <= ~acc_addr;
    acc_nonsec <= ~acc_nonsec;
  endtask : stop
endmodule : sad_core_model

// *** bench/sad_top_test.sv ***
// Purpose: Self-checking bench of the attribution block
// Assumes: 20 MHz clock, option pins held steady across reset
// Notes:   Flash watermark holds only the top page
`timescale 1ns/1ps
`include "sad_params.svh"
module sad_top_test;
  logic               clk_sys, resetn, opt_sec_enable, reg_wr, reg_rd, reg_nonsec;
  logic [6:0]         opt_wm_start, opt_wm_end;
  logic [7:0]         reg_addr;
  logic [31:0]        opt_boot_addr, reg_wdata, reg_rdata, acc_addr, boot_addr;
  logic               acc_valid, acc_nonsec, acc_fetch, acc_peri, acc_peri_aware, acc_grant, acc_block;
  logic [4:0]         acc_peri_idx;
  sad_pkg::sad_attr_e acc_attr;
  logic               sec_enabled, cpu_secure, col_irq;
  logic [31:0]        gpio_secure, irq_line_secure, peri_secure;
  int                 fail_count, num_checks;

  sad_top sad_top_i (.clk_sys, .resetn, .opt_sec_enable, .opt_wm_start, .opt_wm_end, .opt_boot_addr,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_nonsec, .reg_rdata, .acc_valid, .acc_addr, .acc_nonsec,
    .acc_fetch, .acc_peri, .acc_peri_aware, .acc_peri_idx, .acc_grant, .acc_block, .acc_attr,
    .sec_enabled, .cpu_secure, .boot_addr, .gpio_secure, .irq_line_secure, .peri_secure, .col_irq);
  sad_core_model sad_core_model_i (.clk_sys, .acc_valid, .acc_addr, .acc_nonsec, .acc_fetch, .acc_peri,
    .acc_peri_aware, .acc_peri_idx);

  // 50 ns period
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(logic [7:0] a, logic [31:0] d, logic ns = 1'b0);
    @(posedge clk_sys);
    reg_wr     <= 1'b1;
    reg_addr   <= a;
    reg_wdata  <= d;
    reg_nonsec <= ns;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(string what, logic [7:0] a, logic [31:0] exp, logic ns = 1'b0);
    @(posedge clk_sys);
    reg_rd     <= 1'b1;
    reg_addr   <= a;
    reg_nonsec <= ns;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(what, reg_rdata, exp);
  endtask : rd

  // Attribute 3 means the attribute is left unchecked
  task automatic acc(string what, logic [31:0] a, logic ns, logic f, logic blk, logic [1:0] at = 2'h3,
                     logic p = 1'b0, logic aw = 1'b0);
    sad_core_model_i.issue(a, ns, f, p, aw);
    check({what, " block"}, {31'h0, acc_block}, {31'h0, blk});
    if (at != 2'h3) check({what, " attr"}, {30'h0, acc_attr}, {30'h0, at});
  endtask : acc

  task automatic do_reset(logic en);
    resetn         <= 1'b0;
    opt_sec_enable <= en;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask : do_reset

  task automatic t_off();
    check("sec_enabled", {31'h0, sec_enabled}, 32'h0);
    acc("off alias", 32'h0C00_0000, 1'b1, 1'b0, 1'b0, 2'h0);
    sad_core_model_i.stop();
  endtask : t_off

  task automatic t_reset_state();
    check("boot_addr", boot_addr, 32'h0C00_0000);
    check("gpio", gpio_secure, 32'hFFFF_FFFF);
    check("irq", irq_line_secure, 32'hFFFF_FFFF);
    check("peri", peri_secure, 32'h0000_0000);
    rd("stat ns", `SAD_OFF_STAT, 32'h0000_0007, 1'b1);
    rd("col_en", `SAD_OFF_COL_EN, 32'h0000_0000);
    rd("peri reg", `SAD_OFF_PERI_SEC, 32'h0000_0000);
    rd("irq reg", `SAD_OFF_IRQ_SEC, 32'hFFFF_FFFF);
    rd("guard reg", `SAD_OFF_GUARD_SEC, 32'hFFFF_FFFF);
    rd("unmapped", 8'h3C, 32'h0000_0000);
    wr(`SAD_OFF_GPIO_SEC, 32'h0000_0000, 1'b1);
    rd("gpio ns read", `SAD_OFF_GPIO_SEC, 32'h0000_0000, 1'b1);
    rd("gpio reg", `SAD_OFF_GPIO_SEC, 32'hFFFF_FFFF);
  endtask : t_reset_state

  task automatic t_all_secure();
    acc("s code", 32'h0800_0000, 1'b0, 1'b0, 1'b0, 2'h2);
    acc("ns code", 32'h0800_0000, 1'b1, 1'b0, 1'b1, 2'h2);
    acc("ns fetch alias", 32'h0C00_0000, 1'b1, 1'b1, 1'b1, 2'h2);
  endtask : t_all_secure

  task automatic t_regions();
    wr(`SAD_OFF_CTRL, 32'h0000_0001);
    wr(8'h78, 32'h0800_0000);
    wr(8'h7C, 32'h080F_FFE1);
    wr(8'h40, 32'h0C00_0000);
    wr(8'h44, 32'h0C00_00E1);
    wr(8'h48, 32'h2000_0000);
    wr(8'h4C, 32'h2000_03E1);
    wr(8'h50, 32'h4000_0000);
    wr(8'h54, 32'h4FFF_FFE1);
    acc("rgn7 low", 32'h0800_0000, 1'b1, 1'b0, 1'b0, 2'h0);
    acc("rgn7 page126", 32'h080F_C000, 1'b1, 1'b0, 1'b0, 2'h0);
    acc("watermark", 32'h080F_FFE0, 1'b1, 1'b0, 1'b1);
    acc("past limit", 32'h0810_0000, 1'b1, 1'b0, 1'b1, 2'h2);
    acc("s to ns", 32'h0800_0000, 1'b0, 1'b0, 1'b1, 2'h0);
    acc("nsc fetch", 32'h0C00_0000, 1'b1, 1'b1, 1'b0, 2'h1);
    acc("nsc data", 32'h0C00_0000, 1'b1, 1'b0, 1'b1, 2'h1);
    acc("s to nsc", 32'h0C00_0080, 1'b0, 1'b0, 1'b0, 2'h1);
    wr(8'h58, 32'h0800_2000);
    wr(8'h5C, 32'h0800_2003);
    acc("rgn nsc", 32'h0800_2000, 1'b1, 1'b1, 1'b0, 2'h1);
  endtask : t_regions

  task automatic t_guard();
    acc("page0 secure", 32'h2000_0000, 1'b1, 1'b0, 1'b1);
    wr(`SAD_OFF_GUARD_SEC, 32'hFFFF_FFFE, 1'b1);
    acc("page0 ns write", 32'h2000_0000, 1'b1, 1'b0, 1'b1);
    wr(`SAD_OFF_GUARD_SEC, 32'hFFFF_FFFE);
    acc("page0 open", 32'h2000_0000, 1'b1, 1'b0, 1'b0);
    acc("page0 top", 32'h2000_01FC, 1'b1, 1'b0, 1'b0);
    acc("page1", 32'h2000_0200, 1'b1, 1'b0, 1'b1);
    acc("page0 s alias", 32'h3000_0000, 1'b0, 1'b0, 1'b1);
  endtask : t_guard

  task automatic t_peri();
    acc("gate open", 32'h4000_0000, 1'b1, 1'b0, 1'b0, 2'h0, 1'b1);
    wr(`SAD_OFF_PERI_SEC, 32'h0000_0008);
    #1 check("peri port", peri_secure, 32'h0000_0008);
    acc("gate shut", 32'h4000_0000, 1'b1, 1'b0, 1'b1, 2'h0, 1'b1);
    acc("aware", 32'h4000_0000, 1'b1, 1'b0, 1'b0, 2'h0, 1'b1, 1'b1);
  endtask : t_peri

  task automatic t_collector();
    sad_core_model_i.stop();
    wr(`SAD_OFF_COL_FLAG, 32'h0000_0007);
    #1 check("irq idle", {31'h0, col_irq}, 32'h0);
    wr(`SAD_OFF_COL_EN, 32'h0000_0001);
    acc("violation", 32'h0810_0000, 1'b1, 1'b0, 1'b1);
    sad_core_model_i.stop();
    rd("flags", `SAD_OFF_COL_FLAG, 32'h0000_0001);
    check("col_irq", {31'h0, col_irq}, 32'h1);
    wr(`SAD_OFF_COL_FLAG, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    #1 check("col_irq clear", {31'h0, col_irq}, 32'h0);
  endtask : t_collector

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // Whole run takes well under 400 cycles
  initial begin
    #(4000 * 50);
    fail_count++;
    summarize();
  end

  // Main sequence: one run with security off, one with it on
  initial begin
    resetn = 1'b0;
    {opt_sec_enable, reg_wr, reg_rd, reg_nonsec, reg_addr, reg_wdata} = '0;
    opt_wm_start  = 7'h7F;
    opt_wm_end    = 7'h7F;
    opt_boot_addr = 32'h0800_0000;
    fail_count    = 0;
    num_checks    = 0;
    do_reset(1'b0);
    t_off();
    do_reset(1'b1);
    t_reset_state();
    t_all_secure();
    t_regions();
    t_guard();
    t_peri();
    t_collector();
    summarize();
  end
endmodule : sad_top_test

bind sad_top sad_top_sva #(.NPERI(NPERI), .NGPIO(NGPIO), .NIRQ(NIRQ)) sad_top_sva_i (.clk_sys, .resetn,
  .acc_valid, .acc_addr, .acc_nonsec, .acc_fetch, .acc_grant, .acc_block, .acc_attr, .sec_enabled,
  .cpu_secure, .boot_addr, .gpio_secure, .irq_line_secure, .peri_secure, .col_irq);
